/* hdl/sdcbc_bank.sv */
// state and open row of one dram bank
`timescale 1ns/100ps
module sdcbc_bank
(
	// clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         rst_n_i,
	// command pulses addressed to this bank
	input  wire logic                         act_i,
	input  wire logic                         rd_i,
	input  wire logic                         wr_i,
	input  wire logic                         pre_i,
	input  wire logic                         done_i,
	input  wire logic [sdcbc_pkg::ROW_W-1:0]  row_i,
	// state
	output sdcbc_pkg::sdcbc_bank_t            state_o,
	output logic      [sdcbc_pkg::ROW_W-1:0]  row_o
);

	sdcbc_pkg::sdcbc_bank_t state_ff;
	sdcbc_pkg::sdcbc_bank_t nxt_state;
	logic [sdcbc_pkg::ROW_W-1:0] row_ff;
	logic [7:0]                  rp_cnt_ff;

	assign state_o = state_ff;
	assign row_o   = row_ff;

	// ------------------------------------------------------------------
	// bank state machine
	// ------------------------------------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			sdcbc_pkg::SDCBC_IDLE:
			begin
				if (act_i)
					nxt_state = sdcbc_pkg::SDCBC_ACTIVE;
			end
			sdcbc_pkg::SDCBC_ACTIVE, sdcbc_pkg::SDCBC_READ, sdcbc_pkg::SDCBC_WRITE:
			begin
				if (pre_i)
					nxt_state = sdcbc_pkg::SDCBC_PRECHG;
				else if (rd_i)
					nxt_state = sdcbc_pkg::SDCBC_READ;
				else if (wr_i)
					nxt_state = sdcbc_pkg::SDCBC_WRITE;
				else if (done_i)
					nxt_state = sdcbc_pkg::SDCBC_ACTIVE;
			end
			sdcbc_pkg::SDCBC_PRECHG:
			begin
				if (rp_cnt_ff == 8'(sdcbc_pkg::RP_CYC - 1))
					nxt_state = sdcbc_pkg::SDCBC_IDLE;
			end
			default:
				nxt_state = sdcbc_pkg::SDCBC_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state_ff <= sdcbc_pkg::SDCBC_IDLE;
		else
			state_ff <= nxt_state;
	end

	// precharge period counter
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rp_cnt_ff <= 8'h00;
		else if (state_ff == sdcbc_pkg::SDCBC_PRECHG)
			rp_cnt_ff <= rp_cnt_ff + 8'h01;
		else
			rp_cnt_ff <= 8'h00;
	end

	// open row, kept until the next activate
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			row_ff <= '0;
		else if (act_i && state_ff == sdcbc_pkg::SDCBC_IDLE)
			row_ff <= row_i;
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	property p_act_opens;
		@(posedge clk_i) disable iff (!rst_n_i)
		(act_i && state_ff == sdcbc_pkg::SDCBC_IDLE) |=>
			(state_ff == sdcbc_pkg::SDCBC_ACTIVE && row_ff == $past(row_i));
	endproperty
	a_act_opens: assert property (p_act_opens)
		else $error("activate did not open the row");

	property p_pre_to_idle;
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(state_ff == sdcbc_pkg::SDCBC_PRECHG) |->
			(state_ff == sdcbc_pkg::SDCBC_PRECHG) ##1 (state_ff == sdcbc_pkg::SDCBC_IDLE);
	endproperty
	a_pre_to_idle: assert property (p_pre_to_idle)
		else $error("bank not idle one precharge period after precharge");

endmodule

/* hdl/sdcbc_pkg.sv */
// shared constants and types of the dram command and bank control block
package sdcbc_pkg;

	// ------------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------------
	localparam int NUM_BANKS = 4;
	localparam int BA_W      = 2;
	localparam int ADDR_W    = 13;
	localparam int ROW_W     = 13;
	localparam int NUM_ROWS  = 8192;
	localparam int COL_W     = 11;
	localparam int OP_W      = 12;
	localparam int MODE_W    = OP_W + BA_W;
	localparam int AP_BIT    = 10;
	localparam int A11_BIT   = 11;
	localparam int X4_COLS   = 2048;
	localparam int X8_COLS   = 1024;
	localparam int X16_COLS  = 512;

	// ------------------------------------------------------------------
	// command codes as {row strobe, column strobe, write enable}
	// ------------------------------------------------------------------
	localparam logic [2:0] CMD_NOP  = 3'h7;
	localparam logic [2:0] CMD_ACT  = 3'h3;
	localparam logic [2:0] CMD_RD   = 3'h5;
	localparam logic [2:0] CMD_WR   = 3'h4;
	localparam logic [2:0] CMD_BT   = 3'h6;
	localparam logic [2:0] CMD_PRE  = 3'h2;
	localparam logic [2:0] CMD_REF  = 3'h1;
	localparam logic [2:0] mode_load_command = 3'h0;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int T_RP_NS       = 20;
	localparam int T_REFI_NS     = 7813;
	localparam int RP_CYC        = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REFI_CYC      = T_REFI_NS / CLK_PERIOD_NS;
	localparam int DQM_RD_LAT    = 2;
	localparam int BURST_LEN     = 4;

	// ------------------------------------------------------------------
	// per-bank state
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		SDCBC_IDLE   = 3'b000,
		SDCBC_ACTIVE = 3'b001,
		SDCBC_READ   = 3'b011,
		SDCBC_WRITE  = 3'b010,
		SDCBC_PRECHG = 3'b110
	} sdcbc_bank_t;

endpackage

/* hdl/sdcbc_top.sv */
// command decoding, burst sequencing and bank control of a quad-bank dram
// How it works
// - all command, address, mask and data inputs are taken on the rising clock edge
// - four banks of 8192 rows; 2048, 1024 or 512 columns by data width
// - activate opens the row on the address lines in the addressed bank
// - burst start column taken from address bits chosen by data width
// - chip select low: row, column, write strobes decode the eight commands
// - refresh code refreshes with clock enable high, enters self refresh when low
// - refresh rows come from an internal counter; other inputs ignored
// - address bit 10 on read or write selects auto precharge for that access
// - precharge closes one bank, or all banks when address bit 10 high
// - mode load stores address bits 11..0 with bank address in mode register
// - chip select high ignores commands; running bursts continue
// - no operation registers nothing and leaves running bursts alone
// - an opened row stays open until that bank is precharged
// - read mask high floats the data lines two clocks later
// - write mask sampled with the write data blocks that write
// - auto precharge closes the row when the burst ends; otherwise row stays open
// - a precharged bank is idle after the precharge period, needs activate
// - burst terminate cuts the most recent read or write burst
`timescale 1ns/100ps
module sdcbc_top
#(
	parameter int DQ_W      = 4,
	parameter int BURST_LEN = sdcbc_pkg::BURST_LEN,
	parameter int REFI_CYC  = sdcbc_pkg::REFI_CYC
)
(
	// clock and reset
	input  wire logic                                  SYS_CLK_I,
	input  wire logic                                  RST_N_I,
	// command pins
	input  wire logic                                  CKE_I,
	input  wire logic                                  CS_N_I,
	input  wire logic                                  RAS_N_I,
	input  wire logic                                  CAS_N_I,
	input  wire logic                                  WE_N_I,
	input  wire logic [sdcbc_pkg::BA_W-1:0]            BA_I,
	input  wire logic [sdcbc_pkg::ADDR_W-1:0]          ADDR_I,
	// data pins
	input  wire logic                                  DQM_I,
	input  wire logic [DQ_W-1:0]                       DQ_I,
	output logic      [DQ_W-1:0]                       DQ_O,
	output logic                                       DQ_OE_O,
	// array access
	output logic                                       ARRAY_WE_O,
	output logic                                       ARRAY_RE_O,
	output logic      [sdcbc_pkg::BA_W-1:0]            ARRAY_BANK_O,
	output logic      [sdcbc_pkg::ROW_W-1:0]           ARRAY_ROW_O,
	output logic      [sdcbc_pkg::COL_W-1:0]           ARRAY_COL_O,
	output logic      [DQ_W-1:0]                       ARRAY_WDATA_O,
	input  wire logic [DQ_W-1:0]                       ARRAY_RDATA_I,
	output logic                                       ARRAY_REF_O,
	output logic      [sdcbc_pkg::ROW_W-1:0]           REF_ROW_O,
	// status
	output logic      [sdcbc_pkg::MODE_W-1:0]          MODE_REG_O,
	output logic                                       SELF_REF_O,
	output logic      [3*sdcbc_pkg::NUM_BANKS-1:0]     BANK_STATE_O
);

	localparam int NB = sdcbc_pkg::NUM_BANKS;
	localparam int NUM_COLS = (DQ_W == 4) ? sdcbc_pkg::X4_COLS :
		(DQ_W == 8) ? sdcbc_pkg::X8_COLS : sdcbc_pkg::X16_COLS;
	localparam logic [sdcbc_pkg::COL_W-1:0] COL_MASK = sdcbc_pkg::COL_W'(NUM_COLS - 1);
	localparam logic [7:0] BEATS = 8'(BURST_LEN);

	// ------------------------------------------------------------------
	// input registers
	// ------------------------------------------------------------------
	logic                           cke_q;
	logic                           cs_n_q;
	logic [2:0]                     cmd_q;
	logic [sdcbc_pkg::BA_W-1:0]     ba_q;
	logic [sdcbc_pkg::ADDR_W-1:0]   addr_q;
	logic                           dqm_q;
	logic [DQ_W-1:0]                dq_q;

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			cke_q  <= 1'b0;
			cs_n_q <= 1'b1;
			cmd_q  <= sdcbc_pkg::CMD_NOP;
			ba_q   <= '0;
			addr_q <= '0;
			dqm_q  <= 1'b1;
			dq_q   <= '0;
		end
		else
		begin
			cke_q  <= CKE_I;
			cs_n_q <= CS_N_I;
			cmd_q  <= {RAS_N_I, CAS_N_I, WE_N_I};
			ba_q   <= BA_I;
			addr_q <= ADDR_I;
			dqm_q  <= DQM_I;
			dq_q   <= DQ_I;
		end
	end

	// ------------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------------
	logic self_ref_ff;
	logic sel;
	logic cmd_ok;
	logic is_act;
	logic is_rd;
	logic is_wr;
	logic is_bt;
	logic is_pre;
	logic is_ref;
	logic is_mld;
	logic start;
	logic ap_req;
	logic [sdcbc_pkg::COL_W-1:0] col_dec;

	assign sel    = !cs_n_q && !self_ref_ff;
	assign cmd_ok = sel && cke_q;
	assign is_act = cmd_ok && cmd_q == sdcbc_pkg::CMD_ACT;
	assign is_rd  = cmd_ok && cmd_q == sdcbc_pkg::CMD_RD;
	assign is_wr  = cmd_ok && cmd_q == sdcbc_pkg::CMD_WR;
	assign is_bt  = cmd_ok && cmd_q == sdcbc_pkg::CMD_BT;
	assign is_pre = cmd_ok && cmd_q == sdcbc_pkg::CMD_PRE;
	assign is_ref = sel && cmd_q == sdcbc_pkg::CMD_REF;
	assign is_mld = cmd_ok && cmd_q == sdcbc_pkg::mode_load_command;
	assign start  = is_rd || is_wr;
	assign ap_req = addr_q[sdcbc_pkg::AP_BIT];

	// starting column by data width
	always_comb
	begin
		if (DQ_W == 4)
			col_dec = {addr_q[sdcbc_pkg::A11_BIT], addr_q[9:0]};
		else if (DQ_W == 8)
			col_dec = {1'b0, addr_q[9:0]};
		else
			col_dec = {2'b00, addr_q[8:0]};
	end

	// ------------------------------------------------------------------
	// burst sequencer
	// ------------------------------------------------------------------
	logic                          burst_on_ff;
	logic                          burst_wr_ff;
	logic                          burst_ap_ff;
	logic [sdcbc_pkg::BA_W-1:0]    burst_bank_ff;
	logic [sdcbc_pkg::COL_W-1:0]   burst_col_ff;
	logic [7:0]                    beats_left_ff;
	logic                          pre_cut;
	logic                          acc_now;
	logic                          acc_wr;
	logic [sdcbc_pkg::BA_W-1:0]    acc_bank;
	logic [sdcbc_pkg::COL_W-1:0]   acc_col;
	logic                          last_beat;
	logic                          end_evt;
	logic                          end_ap;
	logic [sdcbc_pkg::BA_W-1:0]    end_bank;

	assign pre_cut  = is_pre && (ap_req || ba_q == burst_bank_ff);
	assign acc_now  = start || (burst_on_ff && !is_bt && !pre_cut);
	assign acc_wr   = start ? is_wr : burst_wr_ff;
	assign acc_bank = start ? ba_q : burst_bank_ff;
	assign acc_col  = start ? col_dec : burst_col_ff;
	assign last_beat = start ? (BEATS == 8'h01) : (beats_left_ff == 8'h01);

	// burst end: natural last beat, terminate, or a new access elsewhere
	always_comb
	begin
		end_evt  = 1'b0;
		end_ap   = burst_ap_ff;
		end_bank = burst_bank_ff;
		if (acc_now && last_beat)
		begin
			end_evt  = 1'b1;
			end_ap   = start ? ap_req : burst_ap_ff;
			end_bank = acc_bank;
		end
		else if (burst_on_ff && (is_bt || (start && ba_q != burst_bank_ff)))
			end_evt  = 1'b1;
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			burst_on_ff <= 1'b0;
		else
			burst_on_ff <= acc_now && !last_beat;
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			burst_wr_ff   <= 1'b0;
			burst_ap_ff   <= 1'b0;
			burst_bank_ff <= '0;
			burst_col_ff  <= '0;
			beats_left_ff <= 8'h00;
		end
		else if (acc_now)
		begin
			burst_wr_ff   <= acc_wr;
			burst_ap_ff   <= start ? ap_req : burst_ap_ff;
			burst_bank_ff <= acc_bank;
			burst_col_ff  <= (acc_col + sdcbc_pkg::COL_W'(1)) & COL_MASK;
			beats_left_ff <= start ? BEATS - 8'h01 : beats_left_ff - 8'h01;
		end
	end

	// ------------------------------------------------------------------
	// banks
	// ------------------------------------------------------------------
	sdcbc_pkg::sdcbc_bank_t       bank_state [NB];
	logic [sdcbc_pkg::ROW_W-1:0]  bank_row   [NB];

	generate
		for (genvar b = 0; b < NB; b++)
		begin : g_bank
			logic hit;
			assign hit = ba_q == sdcbc_pkg::BA_W'(b);
			sdcbc_bank u_bank
			(
				.clk_i   (SYS_CLK_I),
				.rst_n_i (RST_N_I),
				.act_i   (is_act && hit),
				.rd_i    (is_rd && hit),
				.wr_i    (is_wr && hit),
				.pre_i   ((is_pre && (ap_req || hit)) ||
					(end_evt && end_ap && end_bank == sdcbc_pkg::BA_W'(b))),
				.done_i  (end_evt && !end_ap && end_bank == sdcbc_pkg::BA_W'(b)),
				.row_i   (addr_q),
				.state_o (bank_state[b]),
				.row_o   (bank_row[b])
			);
			assign BANK_STATE_O[3*b +: 3] = bank_state[b];
		end
	endgenerate

	// ------------------------------------------------------------------
	// array access and data path
	// ------------------------------------------------------------------
	logic dqm_d1_ff;

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			ARRAY_WE_O    <= 1'b0;
			ARRAY_RE_O    <= 1'b0;
			ARRAY_BANK_O  <= '0;
			ARRAY_ROW_O   <= '0;
			ARRAY_COL_O   <= '0;
			ARRAY_WDATA_O <= '0;
		end
		else
		begin
			ARRAY_WE_O    <= acc_now && acc_wr && !dqm_q;
			ARRAY_RE_O    <= acc_now && !acc_wr;
			ARRAY_BANK_O  <= acc_bank;
			ARRAY_ROW_O   <= bank_row[acc_bank];
			ARRAY_COL_O   <= acc_col;
			ARRAY_WDATA_O <= dq_q;
		end
	end

	// read data leaves two clocks after its beat, floated by the mask
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			dqm_d1_ff <= 1'b1;
			DQ_OE_O   <= 1'b0;
			DQ_O      <= '0;
		end
		else
		begin
			dqm_d1_ff <= dqm_q;
			DQ_OE_O   <= ARRAY_RE_O && !dqm_d1_ff;
			DQ_O      <= ARRAY_RDATA_I;
		end
	end

	// ------------------------------------------------------------------
	// mode register
	// ------------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			MODE_REG_O <= '0;
		else if (is_mld)
			MODE_REG_O <= {ba_q, addr_q[sdcbc_pkg::OP_W-1:0]};
	end

	// ------------------------------------------------------------------
	// refresh
	// ------------------------------------------------------------------
	logic [sdcbc_pkg::ROW_W-1:0] ref_cnt_ff;
	logic [15:0]                 sr_tick_ff;
	logic                        sr_ref;
	logic                        do_ref;

	assign sr_ref = self_ref_ff && sr_tick_ff == 16'(REFI_CYC - 1);
	assign do_ref = (is_ref && cke_q) || sr_ref;

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			self_ref_ff <= 1'b0;
		else if (is_ref && !cke_q)
			self_ref_ff <= 1'b1;
		else if (cke_q)
			self_ref_ff <= 1'b0;
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			sr_tick_ff <= 16'h0000;
		else if (!self_ref_ff || sr_ref)
			sr_tick_ff <= 16'h0000;
		else
			sr_tick_ff <= sr_tick_ff + 16'h0001;
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			ref_cnt_ff  <= '0;
			ARRAY_REF_O <= 1'b0;
			REF_ROW_O   <= '0;
		end
		else
		begin
			ARRAY_REF_O <= do_ref;
			if (do_ref)
			begin
				REF_ROW_O  <= ref_cnt_ff;
				ref_cnt_ff <= ref_cnt_ff + sdcbc_pkg::ROW_W'(1);
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			SELF_REF_O <= 1'b0;
		else
			SELF_REF_O <= self_ref_ff;
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	property p_rd_mask_hiz;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		(acc_now && !acc_wr && dqm_q) |-> ##2 !DQ_OE_O;
	endproperty
	a_rd_mask_hiz: assert property (p_rd_mask_hiz)
		else $error("masked read beat drove the data lines");

	property p_rd_drive;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		(acc_now && !acc_wr && !dqm_q) |-> ##2 DQ_OE_O;
	endproperty
	a_rd_drive: assert property (p_rd_drive)
		else $error("unmasked read beat not driven two clocks later");

	property p_wr_mask;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		(acc_now && acc_wr) |=> (ARRAY_WE_O == !$past(dqm_q));
	endproperty
	a_wr_mask: assert property (p_wr_mask)
		else $error("write mask not honoured");

	property p_deselect;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		(cs_n_q && !burst_on_ff && !self_ref_ff) |=> !ARRAY_WE_O && !ARRAY_RE_O && !ARRAY_REF_O;
	endproperty
	a_deselect: assert property (p_deselect)
		else $error("deselected device acted on a command");

	property p_mode_load;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		is_mld |=> MODE_REG_O == $past({ba_q, addr_q[sdcbc_pkg::OP_W-1:0]});
	endproperty
	a_mode_load: assert property (p_mode_load)
		else $error("mode register not loaded");

	property p_auto_ref;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		(is_ref && cke_q) |=> ARRAY_REF_O && REF_ROW_O == $past(ref_cnt_ff);
	endproperty
	a_auto_ref: assert property (p_auto_ref)
		else $error("auto refresh not taken from the counter");

	property p_self_ref;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		(is_ref && !cke_q) |=> ##1 SELF_REF_O;
	endproperty
	a_self_ref: assert property (p_self_ref)
		else $error("self refresh not entered");

	property p_term;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		(is_bt && burst_on_ff && !start) |=> !burst_on_ff && !ARRAY_WE_O && !ARRAY_RE_O;
	endproperty
	a_term: assert property (p_term)
		else $error("burst not terminated");

	property p_ap_close;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		(end_evt && end_ap) |=> bank_state[$past(end_bank)] == sdcbc_pkg::SDCBC_PRECHG;
	endproperty
	a_ap_close: assert property (p_ap_close)
		else $error("auto precharge did not close the row");

endmodule

/* test/sdcbc_ctl_model.sv */
// controller model that drives the command, address and write data pins
`timescale 1ns/100ps
module sdcbc_ctl_model
(
	// clock
	input  wire logic                          clk_i,
	// command, address and data pins
	output logic                               cke_o,
	output logic                               cs_n_o,
	output logic [2:0]                         cmd_o,
	output logic [sdcbc_pkg::BA_W-1:0]         ba_o,
	output logic [sdcbc_pkg::ADDR_W-1:0]       addr_o,
	output logic                               dqm_o,
	output logic [3:0]                         dq_o
);
	initial
	begin
		{cke_o, cs_n_o, cmd_o, ba_o, addr_o, dqm_o, dq_o} = {2'h3, 3'h7, 20'h00000};
	end

	// one command cycle, changed just after an edge and held to the next
	// callers only send commands legal for the bank state
	task automatic drv(input logic k, input logic s, input logic [2:0] c,
		input logic [1:0] b, input logic [12:0] a, input logic m, input logic [3:0] d);
		@(posedge clk_i);
		cke_o  <= k;
		cs_n_o <= s;
		cmd_o  <= c;
		ba_o   <= b;
		addr_o <= a;
		dqm_o  <= m;
		dq_o   <= d;
		#1;
	endtask
endmodule

/* test/tb.sv */
// self-checking bench of the dram command and bank control block
`timescale 1ns/100ps
module tb;
	// ------------------------------------------------------------------
	// signals and device
	// ------------------------------------------------------------------
	logic        clk, rst_n, cke, cs_n, dqm, dq_oe, a_we, a_re, a_ref, self_ref;
	logic [2:0]  cmd_bits;
	logic [1:0]  ba, a_bank;
	logic [12:0] addr, a_row, ref_row;
	logic [10:0] a_col;
	logic [3:0]  dq, dq_o, a_wd, a_rd;
	logic [13:0] mode;
	logic [11:0] bst;
	int          failures = 0;
	int          cmp_count = 0;
	int          cyc = 0;

	// array answers in the same cycle as a read pulse, else a changing pattern
	assign a_rd = a_re ? (a_col[3:0] ^ 4'hA) : 4'(cyc);

	sdcbc_ctl_model ctl (.clk_i(clk), .cke_o(cke), .cs_n_o(cs_n), .cmd_o(cmd_bits),
		.ba_o(ba), .addr_o(addr), .dqm_o(dqm), .dq_o(dq));

	sdcbc_top #(.DQ_W(4), .REFI_CYC(8)) uut (.SYS_CLK_I(clk), .RST_N_I(rst_n),
		.CKE_I(cke), .CS_N_I(cs_n), .RAS_N_I(cmd_bits[2]), .CAS_N_I(cmd_bits[1]),
		.WE_N_I(cmd_bits[0]), .BA_I(ba), .ADDR_I(addr), .DQM_I(dqm), .DQ_I(dq),
		.DQ_O(dq_o), .DQ_OE_O(dq_oe), .ARRAY_WE_O(a_we), .ARRAY_RE_O(a_re),
		.ARRAY_BANK_O(a_bank), .ARRAY_ROW_O(a_row), .ARRAY_COL_O(a_col),
		.ARRAY_WDATA_O(a_wd), .ARRAY_RDATA_I(a_rd), .ARRAY_REF_O(a_ref),
		.REF_ROW_O(ref_row), .MODE_REG_O(mode), .SELF_REF_O(self_ref),
		.BANK_STATE_O(bst));

	// steady clock through every access
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ------------------------------------------------------------------
	// helpers and scenarios
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [2:0] bs(input int b);
		return bst[3*b +: 3];
	endfunction

	task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
		ctl.drv(1'b1, 1'b0, c, b, a, 1'b0, 4'h0);
	endtask

	task automatic nop(input int n);
		repeat (n) cmd(sdcbc_pkg::CMD_NOP, 2'h0, 13'h0000);
	endtask

	// rows spread over the array
	task automatic act(input int b, input logic [12:0] row);
		cmd(sdcbc_pkg::CMD_ACT, 2'(b), row);
		nop(2);
		chk(bs(b), sdcbc_pkg::SDCBC_ACTIVE);
	endtask

	// masked write beat, column bit from A11, auto precharge closes the row
	task automatic t_wr_ap();
		act(1, 13'h1ABC);
		ctl.drv(1'b1, 1'b0, sdcbc_pkg::CMD_WR, 2'h1, 13'h0C02, 1'b0, 4'h1);
		for (int j = 1; j < 9; j++)
		begin
			ctl.drv(1'b1, 1'b0, sdcbc_pkg::CMD_NOP, 2'h0, 13'h0000, j == 2, 4'(j + 1));
			if (j >= 2 && j <= 5)
				chk(a_we, j != 4);
			if (j == 2)
				chk({a_bank, a_row}, {2'h1, 13'h1ABC});
			if (j >= 2 && j <= 5 && j != 4)
				chk({a_col, a_wd}, {11'(16'h0400 + j), 4'(j - 1)});
		end
		chk(bs(1), sdcbc_pkg::SDCBC_IDLE);
	endtask

	// read with one masked beat, row stays open without auto precharge
	task automatic t_rd();
		act(1, 13'h0123);
		ctl.drv(1'b1, 1'b0, sdcbc_pkg::CMD_RD, 2'h1, 13'h0005, 1'b0, 4'h0);
		// mask goes with the second beat, registered one edge after the read
		ctl.drv(1'b1, 1'b0, sdcbc_pkg::CMD_NOP, 2'h0, 13'h0000, 1'b1, 4'h0);
		for (int i = 1; i < 7; i++)
		begin
			ctl.drv(1'b1, 1'b0, sdcbc_pkg::CMD_NOP, 2'h0, 13'h0000, 1'b0, 4'(i));
			chk(a_re, i <= 4);
			if (i <= 4)
				chk(a_col, 11'(4 + i));
			if (i == 2)
				chk(bs(1), sdcbc_pkg::SDCBC_READ);
			chk(dq_oe, i >= 2 && i <= 5 && i != 3);
			if (i >= 2 && i <= 5 && i != 3)
				chk(dq_o, 4'(3 + i) ^ 4'hA);
		end
		chk(bs(1), sdcbc_pkg::SDCBC_ACTIVE);
	endtask

	task automatic t_bt();
		int n;
		n = 0;
		cmd(sdcbc_pkg::CMD_RD, 2'h1, 13'h0000);
		cmd(sdcbc_pkg::CMD_BT, 2'h0, 13'h0000);
		repeat (7)
		begin
			nop(1);
			n += a_re;
		end
		chk(n, 1);
		chk(bs(1), sdcbc_pkg::SDCBC_ACTIVE);
	endtask

	task automatic t_pre();
		act(0, 13'h0003);
		act(2, 13'h0004);
		cmd(sdcbc_pkg::CMD_PRE, 2'h0, 13'h1BFF);
		nop(2);
		chk(bs(0), sdcbc_pkg::SDCBC_PRECHG);
		nop(1);
		chk({bs(0), bs(2)}, {sdcbc_pkg::SDCBC_IDLE, sdcbc_pkg::SDCBC_ACTIVE});
		cmd(sdcbc_pkg::CMD_PRE, 2'h3, 13'h0400);
		nop(3);
		chk(bst, 12'h000);
	endtask

	task automatic t_mode_ref();
		int n;
		cmd(sdcbc_pkg::mode_load_command, 2'h2, 13'h1ABC);
		nop(2);
		chk(mode, 14'h2ABC);
		cmd(sdcbc_pkg::CMD_REF, 2'h1, 13'h1FFF);
		nop(1);
		chk(a_ref, 1'b0);
		nop(1);
		chk({a_ref, bst, ref_row}, {1'b1, 12'h000, 13'h0000});
		ctl.drv(1'b1, 1'b1, sdcbc_pkg::CMD_ACT, 2'h3, 13'h0005, 1'b0, 4'h0);
		nop(2);
		chk(bs(3), sdcbc_pkg::SDCBC_IDLE);
		ctl.drv(1'b0, 1'b0, sdcbc_pkg::CMD_REF, 2'h0, 13'h0000, 1'b0, 4'h0);
		n = 0;
		repeat (20)
		begin
			ctl.drv(1'b0, 1'b0, sdcbc_pkg::CMD_ACT, 2'h3, 13'h0005, 1'b1, 4'h5);
			n += a_ref;
		end
		chk({self_ref, bs(3), ref_row}, {1'b1, sdcbc_pkg::SDCBC_IDLE, 13'h0002});
		chk(n >= 2, 1'b1);
		nop(4);
		chk(self_ref, 1'b0);
	endtask

	task automatic close_out();
		if (failures == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// run
	// ------------------------------------------------------------------
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			failures++;
			close_out();
		end
	end

	initial
	begin
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk({mode, bst}, 26'h0000000);
		t_wr_ap();
		t_rd();
		t_bt();
		t_pre();
		t_mode_ref();
		close_out();
	end
endmodule
